// file: hw/scpc_top.sv
// Purpose: System clock prescaler, oscillator trim and clock command register.
// Assumes: Classic Wishbone slave, 32-bit data, registers in byte lane 0.
// Notes:   One wait state on every access; unmapped reads return zero.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "scpc_regs.svh"
module scpc_top #(
  parameter int AW = 10
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          reset_divide_by_eight_fuse,
  input  wire logic [7:0]    trim_factory_value,
  input  wire logic          source_stable,
  output logic               clk_cpu_tick,
  output logic               clk_io_tick,
  output logic               clk_adc_tick,
  output logic               clk_flash_tick,
  output logic      [7:0]    rc_oscillator_trim,
  output logic               trim_range_select,
  output logic      [6:0]    trim_fine,
  output logic      [3:0]    clock_command_code,
  output logic               command_strobe,
  output logic               prescale_switching
);
  localparam int IW = AW - 2;

  // True when a write carries the unlock bit with every other bit zero.
  function automatic logic is_unlock(input logic [7:0] d);
    return d == `SCPC_UNLOCK_PAT;
  endfunction

  // True when an address selects the register at a given index.
  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
    return (a[AW-1:2] == IW'(idx)) && (a[1:0] == 2'b00);
  endfunction

  scpc_div_if dif ();

  logic                   ack_reg;
  logic [31:0]            dat_reg;
  logic [3:0]             sel_reg;
  logic [3:0]             sel_next;
  logic [7:0]             trim_reg;
  logic [3:0]             cmd_reg;
  logic                   strobe_reg;
  logic                   rdy_reg;
  logic                   stable_prev_reg;
  logic [1:0]             unlock_reg;
  logic [2:0]             ucnt_reg [2];
  logic [2:0]             boot_reg;
  logic [`SCPC_SYNC_W-1:0] sync_a_reg;
  logic [`SCPC_SYNC_W-1:0] sync_b_reg;
  logic [`SCPC_SYNC_W-1:0] sync_c_reg;
  logic [`SCPC_SYNC_W-1:0] filt_reg;
  logic [`SCPC_SYNC_W-1:0] filt_next;

  //////////////////////////////////////////////////////////////////////////
  // Pin inputs pass three flops; a bit moves only when the last two agree.
  // This keeps a slowly settling fuse or strap from loading a half value.
  assign filt_next = (sync_b_reg & ~(sync_b_reg ^ sync_c_reg))
                   | (filt_reg & (sync_b_reg ^ sync_c_reg));

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
      sync_c_reg <= '0;
      filt_reg   <= '0;
    end else begin
      sync_a_reg <= {source_stable, reset_divide_by_eight_fuse, trim_factory_value};
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
      filt_reg   <= filt_next;
    end
  end

  logic       fuse_filt;
  logic       stable_filt;
  logic [7:0] factory_filt;
  assign factory_filt = filt_reg[7:0];
  assign fuse_filt    = filt_reg[8];
  assign stable_filt  = filt_reg[9];

  //////////////////////////////////////////////////////////////////////////
  // Straps are caught a few cycles after reset release, once filtered.
  logic boot_load;
  assign boot_load = (boot_reg == `SCPC_BOOT_LOAD);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      boot_reg <= 3'h0;
    end else if (boot_reg <= `SCPC_BOOT_LOAD) begin
      boot_reg <= boot_reg + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus decode. The answer comes one cycle after the request is seen.
  // A write lands at the edge that raises ack; the master still holds the request
  // through the next edge, so the early landing loses nothing and saves a register.
  logic       req;
  logic       wr;
  logic       hit_trim;
  logic       hit_pre;
  logic       hit_cmd;
  logic [7:0] wd;
  logic [7:0] rd_data;
  logic       pre_wr;
  logic       cmd_wr;
  logic       trim_wr;

  assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign hit_trim = hit(wb_adr_i, `SCPC_IDX_TRIM);
  assign hit_pre  = hit(wb_adr_i, `SCPC_IDX_PRESCALE);
  assign hit_cmd  = hit(wb_adr_i, `SCPC_IDX_CMD);
  assign wd       = wb_dat_i[7:0];
  assign pre_wr   = wr & hit_pre;
  assign cmd_wr   = wr & hit_cmd;
  assign trim_wr  = wr & hit_trim;

  // Reserved bits are built in as zero constants rather than stored.
  assign rd_data = hit_trim ? trim_reg
                 : hit_pre ? {unlock_reg[0], 3'b000, sel_reg}
                 : hit_cmd ? {unlock_reg[1], 2'b00, rdy_reg, cmd_reg}
                 : 8'h00;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (req) begin
        dat_reg <= {24'h00_0000, rd_data};
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  //////////////////////////////////////////////////////////////////////////
  // Two timed unlocks: index 0 guards the select, index 1 the command field.
  // Both count divided ticks, so the window stretches with the ratio.
  logic       cpu_tick;
  logic [1:0] u_wr;
  logic [1:0] u_set;
  logic [1:0] u_load;
  logic [1:0] u_exp;

  assign cpu_tick = dif.tick;
  assign u_wr     = {cmd_wr, pre_wr};

  for (genvar i = 0; i < 2; i++) begin : g_unlock
    assign u_set[i]  = u_wr[i] & is_unlock(wd) & ~unlock_reg[i];
    assign u_load[i] = u_wr[i] & ~wd[`SCPC_UNLOCK_BIT] & unlock_reg[i];
    assign u_exp[i]  = unlock_reg[i] & cpu_tick
                     & (ucnt_reg[i] == `SCPC_UNLOCK_TICKS - 3'h1);

    // A rewrite of the pattern while open touches neither flag nor count.
    // The count restarts only on a fresh set, so repeated pattern writes cannot
    // hold a window open for longer than four ticks.
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        unlock_reg[i] <= scpc_pkg::scpc_lock_closed;
        ucnt_reg[i]   <= 3'h0;
      end else if (u_set[i]) begin
        unlock_reg[i] <= scpc_pkg::scpc_lock_open;
        ucnt_reg[i]   <= 3'h0;
      end else if (u_load[i] || u_exp[i]) begin
        unlock_reg[i] <= scpc_pkg::scpc_lock_closed;
        ucnt_reg[i]   <= 3'h0;
      end else if (unlock_reg[i] && cpu_tick) begin
        ucnt_reg[i]   <= ucnt_reg[i] + 3'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Select register: fuse value at start, then any code through the unlock.
  assign sel_next = boot_load ? (fuse_filt ? `SCPC_SEL_FUSE_ON
                                           : `SCPC_SEL_FUSE_OFF)
                  : u_load[0] ? wd[3:0]
                  : sel_reg;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sel_reg <= `SCPC_SEL_RESET;
    end else begin
      sel_reg <= sel_next;
    end
  end

  // The divider picks the code up at its next period boundary.
  // The flag says a change is pending, not how much of the old period is left.
  assign dif.code           = sel_reg;
  assign prescale_switching = (dif.active != sel_reg);

  scpc_divider #(
    .CW (8)
  ) u_div (
    .mclk  (mclk),
    .reset (reset),
    .dif   (dif)
  );

  // All synchronous domains share one tick so they stay in step.
  assign clk_cpu_tick   = cpu_tick;
  assign clk_io_tick    = cpu_tick;
  assign clk_adc_tick   = cpu_tick;
  assign clk_flash_tick = cpu_tick;

  //////////////////////////////////////////////////////////////////////////
  // Oscillator trim: factory value after reset, software writes freely.
  // Nothing here limits the frequency; nonvolatile timing is software's care.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      trim_reg <= `SCPC_TRIM_RESET;
    end else if (boot_load) begin
      trim_reg <= factory_filt;
    end else if (trim_wr) begin
      trim_reg <= wd;
    end
  end

  assign rc_oscillator_trim = trim_reg;
  assign trim_range_select  = trim_reg[7];
  assign trim_fine          = trim_reg[6:0];

  //////////////////////////////////////////////////////////////////////////
  // Command field and ready flag. A ready event beats a same-cycle clear.
  // Reserved codes are stored so a read shows what was written, but raise no strobe.
  logic act_cmd;
  logic rdy_clr;
  logic rdy_set;

  assign act_cmd = ~wd[3] & (wd[3:0] != scpc_pkg::scpc_cmd_none);
  assign rdy_clr = u_load[1] & ((wd[3:0] == scpc_pkg::scpc_cmd_enable)
                             | (wd[3:0] == scpc_pkg::scpc_cmd_request));
  assign rdy_set = stable_filt & ~stable_prev_reg;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmd_reg         <= `SCPC_CMD_RESET;
      strobe_reg      <= 1'b0;
      rdy_reg         <= 1'b0;
      stable_prev_reg <= 1'b0;
    end else begin
      stable_prev_reg <= stable_filt;
      strobe_reg      <= u_load[1] & act_cmd;
      rdy_reg         <= rdy_set | (rdy_reg & ~rdy_clr);
      if (u_load[1]) begin
        cmd_reg <= wd[3:0];
      end
    end
  end

  assign clock_command_code = cmd_reg;
  assign command_strobe     = strobe_reg;

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  a_unlock_pattern: assert property ($rose(unlock_reg[0]) |-> $past(pre_wr && wd == 8'h80))
    else $error("prescale unlock set without the exact pattern");
  a_unlock_timeout: assert property (unlock_reg[0] && cpu_tick && ucnt_reg[0] == 3'h3
                                     && !u_set[0] |=> !unlock_reg[0])
    else $error("prescale unlock outlived four ticks");
  a_unlock_rewrite: assert property (unlock_reg[0] && pre_wr && wd == 8'h80 && !u_exp[0]
                                     |=> unlock_reg[0]
                                     && ucnt_reg[0] == $past(ucnt_reg[0]) + 3'($past(cpu_tick)))
    else $error("rewrite disturbed the prescale window");
  a_select_guard: assert property ($changed(sel_reg) |-> $past(u_load[0] || boot_load))
    else $error("select changed outside the unlock");
  a_load_closes: assert property (u_load[0] |=> !unlock_reg[0] && sel_reg == $past(wd[3:0]))
    else $error("select write did not close the window");
  a_reserved_zero: assert property (req && hit_pre |=> wb_dat_o[6:4] == 3'b000
                                    && wb_dat_o[31:8] == 24'h00_0000)
    else $error("reserved prescaler bits read nonzero");
  a_fuse_load: assert property (boot_load |=> sel_reg == ($past(fuse_filt) ? 4'h3 : 4'h0))
    else $error("select not loaded from the fuse");
  a_trim_load: assert property (boot_load |=> trim_reg == $past(factory_filt))
    else $error("trim not loaded with the factory value");
  a_ready_clear: assert property (rdy_clr && !rdy_set |=> !rdy_reg)
    else $error("ready flag survived a request");
  a_cmd_guard: assert property (command_strobe |-> $past(u_load[1]) && !cmd_reg[3])
    else $error("command issued without the unlock");

  // The command window gets the pattern, timeout and closing checks of the prescale window, because a
  // fault in one index of the shared counter logic would not show in the other.
  a_cmd_pattern: assert property ($rose(unlock_reg[1]) |-> $past(cmd_wr && wd == 8'h80))
    else $error("command unlock set without the exact pattern");
  a_cmd_timeout: assert property (unlock_reg[1] && cpu_tick && ucnt_reg[1] == 3'h3
                                  |=> !unlock_reg[1])
    else $error("command unlock outlived four ticks");
  a_cmd_closes: assert property (u_load[1]
                                 |=> !unlock_reg[1] && cmd_reg == $past(wd[3:0]))
    else $error("command write did not close the window");

  a_cmd_changed: assert property ($changed(cmd_reg) |-> $past(u_load[1]))
    else $error("command field changed outside the unlock");
  a_strobe_code: assert property (u_load[1] && act_cmd |=> command_strobe)
    else $error("acting command gave no strobe");
  a_cmd_reserved: assert property (req && hit_cmd |=> wb_dat_o[6:5] == 2'b00)
    else $error("reserved command bits read nonzero");
  a_ready_set: assert property (rdy_set |=> rdy_reg)
    else $error("stable source did not set ready");
  a_trim_guard: assert property ($changed(trim_reg) |-> $past(trim_wr || boot_load))
    else $error("trim changed without a write or the factory load");

  c_pre_change: cover property (u_set[0] ##[1:8] u_load[0]);
  c_pre_expire: cover property (u_exp[0]);
  c_cmd_issue: cover property (u_set[1] ##[1:8] command_strobe);
  c_reserved: cover property (u_load[0] && wd[3:0] > 4'h8);
endmodule
`default_nettype wire

// file: common/scpc_regs.svh
// Purpose: Register indices, field positions, reset values and counts.
// Assumes: Indices are word indices; the byte address is four times one.
// Notes:   Definitions only; included by the design files.
`ifndef SCPC_REGS_SVH
`define SCPC_REGS_SVH
`define SCPC_IDX_TRIM      8'h60
`define SCPC_IDX_PRESCALE  8'h61
`define SCPC_IDX_CMD       8'h62
`define SCPC_UNLOCK_BIT    7
`define SCPC_RDY_BIT       4
`define SCPC_UNLOCK_PAT    8'h80
`define SCPC_SEL_FUSE_ON   4'h3
`define SCPC_SEL_FUSE_OFF  4'h0
`define SCPC_SEL_MAX       4'h8
`define SCPC_SEL_RESET     4'h3
`define SCPC_CMD_RESET     4'h0
`define SCPC_TRIM_RESET    8'h00
`define SCPC_UNLOCK_TICKS  3'h4
`define SCPC_BOOT_LOAD     3'h4
`define SCPC_SYNC_W        10
`endif

// file: common/scpc_pkg.sv
// Purpose: Types shared by the clock prescaler block.
// Assumes: Command encodings are fixed by the clock switch module.
// Notes:   Codes with the top bit set mean no command.
package scpc_pkg;
  typedef enum logic [3:0] {
    scpc_cmd_none    = 4'h0,
    scpc_cmd_disable = 4'h1,
    scpc_cmd_enable  = 4'h2,
    scpc_cmd_request = 4'h3,
    scpc_cmd_switch  = 4'h4,
    scpc_cmd_recover = 4'h5,
    scpc_cmd_wdauto  = 4'h6,
    scpc_cmd_clkout  = 4'h7
  } scpc_cmd_t;
  typedef enum logic {
    scpc_lock_closed,
    scpc_lock_open
  } scpc_lock_t;
endpackage

// file: common/scpc_div_if.sv
// Purpose: Carrier between the register side and the divider.
// Assumes: One clock, the undivided master clock.
// Notes:   The control side sets the code; the divider returns ticks.
`timescale 1ns/1ps
`default_nettype none
interface scpc_div_if;
  logic [3:0] code;
  logic [3:0] active;
  logic       tick;
  modport ctrl (output code, input tick, input active);
  modport div  (input code, output tick, output active);
endinterface
`default_nettype wire

// file: hw/scpc_divider.sv
// Purpose: Power-of-two clock divider producing one tick per divided period.
// Assumes: The code input may change at any time.
// Notes:   A new ratio is taken only on a period boundary.
`timescale 1ns/1ps
`default_nettype none
`include "scpc_regs.svh"
module scpc_divider #(
  parameter int CW = 8
) (
  input  wire logic mclk,
  input  wire logic reset,
  scpc_div_if.div   dif
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [CW-1:0] term;
  logic [3:0]    act_reg;
  logic          tick_reg;
  logic          wrap;

  // Terminal count for a code; reserved codes fall back to the largest factor.
  function automatic logic [CW-1:0] ratio_term(input logic [3:0] c);
    logic [CW:0] f;
    f = (CW+1)'(1) << ((c > `SCPC_SEL_MAX) ? `SCPC_SEL_MAX : c);
    return CW'(f - (CW+1)'(1));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Counter at the undivided rate; its state is not visible to software.
  assign term     = ratio_term(act_reg);
  assign wrap     = (cnt_reg == term);
  assign cnt_next = wrap ? '0 : cnt_reg + CW'(1);

  // The ratio swaps only as a period ends, so no short pulse can appear.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_reg  <= '0;
      act_reg  <= `SCPC_SEL_RESET;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= wrap;
      if (wrap) begin
        act_reg <= dif.code;
      end
    end
  end

  assign dif.tick   = tick_reg;
  assign dif.active = act_reg;

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  a_div_bound: assert property (cnt_reg <= term)
    else $error("divider count passed its terminal value");
  a_div_swap: assert property ($changed(act_reg) |-> tick_reg && cnt_reg == '0)
    else $error("ratio changed off a period boundary");
  a_div_tick: assert property (tick_reg |-> $past(cnt_reg) == $past(term))
    else $error("tick without a full period");
  a_div_reserved: assert property (act_reg > `SCPC_SEL_MAX |-> term == CW'(255))
    else $error("reserved code not held at the largest factor");
  c_div_swap: cover property ($changed(act_reg));
endmodule
`default_nettype wire

// file: testbench/scpc_tb.sv
// Purpose: Self-checking bench for the system clock prescaler block.
// Assumes: Classic Wishbone with one wait state; straps are level inputs.
// Notes:   Unlock windows are timed in divided ticks, so long waits run at factor 8.
`timescale 1ns/1ps
`default_nettype none
`include "scpc_regs.svh"
module tb;
  localparam logic [9:0] A_TRIM = 10'h180;
  localparam logic [9:0] A_PRE  = 10'h184;
  localparam logic [9:0] A_CMD  = 10'h188;
  logic        mclk;
  logic        reset;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        fuse;
  logic [7:0]  trim_factory;
  logic        source_stable;
  logic        t_cpu;
  logic        t_io;
  logic        t_adc;
  logic        t_flash;
  logic [7:0]  trim;
  logic        trim_hi;
  logic [6:0]  trim_fine;
  logic [3:0]  cmd_code;
  logic        cmd_strobe;
  logic        switching;
  int          err_total = 0;
  int          checks_done = 0;
  int          strobe_cnt = 0;
  int          n;
  int          s;
  logic [31:0] rd;
  logic [3:0]  codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hF};

  scpc_top #(.AW(10)) dut (
    .mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_divide_by_eight_fuse(fuse),
    .trim_factory_value(trim_factory), .source_stable(source_stable),
    .clk_cpu_tick(t_cpu), .clk_io_tick(t_io), .clk_adc_tick(t_adc),
    .clk_flash_tick(t_flash), .rc_oscillator_trim(trim), .trim_range_select(trim_hi),
    .trim_fine(trim_fine), .clock_command_code(cmd_code), .command_strobe(cmd_strobe),
    .prescale_switching(switching)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // The clock runs at 200 MHz.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Counts strobe pulses so each command write is judged by how many it caused.
  always @(posedge mclk) begin
    if (cmd_strobe === 1'b1) strobe_cnt <= strobe_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and closing report.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Counts: %0d comparisons, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One classic cycle; the idle edge first keeps stb low between requests.
  task automatic wb(input logic we, input logic [9:0] adr, input logic [7:0] wd,
                    input logic sel0, output logic [31:0] rdat);
    int k;
    k = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= {3'h0, sel0};
    wb_dat_i <= {24'h00_0000, wd};
    do begin
      @(posedge mclk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [9:0] adr, input logic [7:0] wd);
    logic [31:0] dummy;
    wb(1'b1, adr, wd, 1'b1, dummy);
  endtask

  task automatic rdchk(input logic [9:0] adr, input logic [7:0] exp);
    logic [31:0] got;
    wb(1'b0, adr, 8'h00, 1'b1, got);
    chk(got, {24'h00_0000, exp});
  endtask

  // Cycles to the next divided tick; all four domain ticks must agree each cycle.
  task automatic next_tick(output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk);
      cnt++;
      chk({t_io, t_adc, t_flash}, {3{t_cpu}});
    end while (t_cpu !== 1'b1 && cnt < 600);
    if (cnt >= 600) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  // Unlock and load a select code, then time the first new periods.
  task automatic set_ratio(input logic [3:0] c);
    int per;
    per = (c > 4'h8) ? 256 : (1 << c);
    wr(A_PRE, 8'h80);
    wr(A_PRE, {4'h0, c});
    // After a long old period the swap is still ahead, so the change must be pending.
    if (n >= 16) chk(switching, 1'b1);
    next_tick(n);
    next_tick(n);
    chk(32'(n), 32'(per));
    next_tick(n);
    chk(32'(n), 32'(per));
    chk(switching, 1'b0);
    rdchk(A_PRE, {4'h0, c});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; the design's inputs all change by NBA at rising edges.
  initial begin
    reset = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    fuse = 1'b1;
    trim_factory = 8'hA5; // Arbitrary factory trim.
    source_stable = 1'b0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (8) @(posedge mclk);
    rdchk(A_PRE, 8'h03);
    rdchk(A_TRIM, 8'hA5);
    rdchk(A_CMD, 8'h00);
    rdchk(10'h1FC, 8'h00);
    next_tick(n);
    next_tick(n);
    chk(32'(n), 32'h0000_0008);
    $display("Test done: reset values");
    // A wrong unlock pattern or an unlocked data write changes nothing.
    wr(A_PRE, 8'h81);
    rdchk(A_PRE, 8'h03);
    wr(A_PRE, 8'h02);
    rdchk(A_PRE, 8'h03);
    // Select codes 0 to 9, reserved code 9 included, at run time.
    for (int i = 0; i < 10; i++) begin
      set_ratio(i == 9 ? 4'h9 : 4'(i));
    end
    set_ratio(4'h3);
    $display("Test done: select codes");
    // Window at factor 8 lasts 25 to 32 cycles; a rewrite must not close it.
    wr(A_PRE, 8'h80);
    rdchk(A_PRE, 8'h83);
    repeat (10) @(posedge mclk);
    wr(A_PRE, 8'h80);
    rdchk(A_PRE, 8'h83);
    wr(A_PRE, 8'h82);
    rdchk(A_PRE, 8'h83);
    repeat (40) @(posedge mclk);
    rdchk(A_PRE, 8'h03);
    wr(A_PRE, 8'h01);
    rdchk(A_PRE, 8'h03);
    $display("Test done: unlock window");
    // Command codes: strobe only for codes 1 to 7, field stored always.
    foreach (codes[i]) begin
      s = strobe_cnt;
      wr(A_CMD, 8'h80);
      wr(A_CMD, {4'h0, codes[i]});
      repeat (3) @(posedge mclk);
      chk(cmd_code, codes[i]);
      chk(32'(strobe_cnt - s), 32'(codes[i] >= 4'h1 && codes[i] <= 4'h7));
      rdchk(A_CMD, {4'h0, codes[i]});
    end
    wr(A_CMD, 8'h05);
    rdchk(A_CMD, 8'h0F);
    source_stable <= 1'b1;
    repeat (8) @(posedge mclk);
    rdchk(A_CMD, 8'h1F);
    wr(A_CMD, 8'h80);
    wr(A_CMD, 8'h03);
    rdchk(A_CMD, 8'h03);
    source_stable <= 1'b0;
    repeat (8) @(posedge mclk);
    source_stable <= 1'b1;
    repeat (8) @(posedge mclk);
    rdchk(A_CMD, 8'h13);
    $display("Test done: command register");
    // Trim ranges and a write with lane 0 disabled.
    // No nonvolatile write runs in this bench, so the trim may go to the top.
    wr(A_TRIM, 8'h7F);
    rdchk(A_TRIM, 8'h7F);
    chk({trim_hi, trim_fine}, 8'h7F);
    wr(A_TRIM, 8'h80);
    chk({trim, trim_hi, trim_fine}, 16'h8080);
    wb(1'b1, A_TRIM, 8'h11, 1'b0, rd);
    rdchk(A_TRIM, 8'h80);
    $display("Test done: trim register");
    // A second reset with the fuse unprogrammed.
    fuse <= 1'b0;
    source_stable <= 1'b0;
    reset <= 1'b1;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (8) @(posedge mclk);
    rdchk(A_PRE, 8'h00);
    rdchk(A_TRIM, 8'hA5);
    rdchk(A_CMD, 8'h00);
    next_tick(n);
    next_tick(n);
    chk(32'(n), 32'h0000_0001);
    $display("Test done: second reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
